// [core/rcs_top.sv]
// first recovered clock output selector with APB control register
// assumes per-port link status from other clock domains; all synced here
//
// Contract
// - bit 15 enables output; off at reset
// - source field picks port 0..3
// - frequency codes: 25, 125, 31.25 MHz
// - level 00 squelches down, unsupported, EEE
// - level 01 also passes master, 10BASE-T
// - level 01 passes clock during LPI
// - level 10 squelches only when down
// - level 11 never squelches
// - squelch pin forces output low
// - type field picks serdes, rx, tx clock
`timescale 1ns/1ns
module rcs_top
    import rcs_pkg::*;
#(
    parameter int NPORTS = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic clock_squelch_in,
    input wire logic [NPORTS-1:0] serdes_link_up,
    input wire logic [NPORTS-1:0] copper_link_up,
    input wire logic [NPORTS-1:0] link_stable,
    input wire logic [NPORTS-1:0] speed_1000,
    input wire logic [NPORTS-1:0] speed_10,
    input wire logic [NPORTS-1:0] phy_master,
    input wire logic [NPORTS-1:0] eee_mode,
    input wire logic [NPORTS-1:0] lpi_receive,
    output logic recovered_clock_out_first,
    output logic recovered_clock_gate
);

    localparam int SW = 8 * NPORTS;

    logic [REG_W-1:0] ctrl;
    logic [SW-1:0] st_meta;
    logic [SW-1:0] st_sync;
    logic pin_meta;
    logic pin_sync;
    logic run;
    logic next_run;

    logic [NPORTS-1:0] serdes_s;
    logic [NPORTS-1:0] copper_s;
    logic [NPORTS-1:0] stable_s;
    logic [NPORTS-1:0] g1000_s;
    logic [NPORTS-1:0] t10_s;
    logic [NPORTS-1:0] master_s;
    logic [NPORTS-1:0] eee_s;
    logic [NPORTS-1:0] lpi_s;

    logic en;
    logic [3:0] src;
    logic [2:0] freq;
    logic [1:0] lvl;
    logic [2:0] typ;
    logic [1:0] sel;

    logic rsvd;
    logic up;
    logic ok;
    logic unsup;
    logic eee_sq;
    logic pass;
    logic can;

    logic setup;
    logic wr;
    logic [31:0] rd_val;
    logic mapped;

    rcs_gen_if gi();

    // field views of the control register
    assign en = ctrl[EN_BIT];
    assign src = ctrl[SRC_LSB +: 4];
    assign freq = ctrl[FREQ_LSB +: 3];
    assign lvl = ctrl[LVL_LSB +: 2];
    assign typ = ctrl[TYPE_LSB +: 3];
    assign sel = src[1:0];

    // status arrives from the port clock domains; each bit is a level
    // and bits may land one cycle apart, which only shifts the decision
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_meta <= '0;
            st_sync <= '0;
        end else begin
            st_meta <= {serdes_link_up, copper_link_up, link_stable, speed_1000,
                        speed_10, phy_master, eee_mode, lpi_receive};
            st_sync <= st_meta;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= clock_squelch_in;
            pin_sync <= pin_meta;
        end
    end

    assign {serdes_s, copper_s, stable_s, g1000_s,
            t10_s, master_s, eee_s, lpi_s} = st_sync;

    // reserved encodings hold run low, so the divider never starts
    assign rsvd = src > SRC_MAX
        || freq > FREQ_31
        || typ > TYPE_CU_TX;

    // tx clock follows the copper link just like the rx clock
    always_comb begin
        if (typ == TYPE_SERDES) begin
            up = serdes_s[sel];
        end else begin
            up = copper_s[sel];
        end
    end

    assign ok = up && stable_s[sel];
    assign unsup = (g1000_s[sel] && master_s[sel]) || t10_s[sel];
    assign eee_sq = eee_s[sel]
        && ((!g1000_s[sel] && !t10_s[sel])
            || (g1000_s[sel] && !master_s[sel]));

    always_comb begin
        case (lvl)
            SQ_AUTO: begin
                pass = ok && !unsup && !eee_sq;
            end
            SQ_LPI: begin
                pass = ok && (!eee_sq || lpi_s[sel]);
            end
            SQ_LINK: begin
                pass = up;
            end
            default: begin
                pass = 1'b1;
            end
        endcase
    end

    assign can = en && !rsvd && !pin_sync;
    assign next_run = can && pass;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b0;
        end else begin
            run <= next_run;
        end
    end

    assign gi.run = run;
    assign gi.freq = freq;

    rcs_clk_gen u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .g(gi.gen)
    );

    assign recovered_clock_out_first = gi.wave;
    assign recovered_clock_gate = gi.gate;

    // apb: zero-wait, answer in the first access cycle
    assign setup = psel && !penable;
    assign wr = psel && penable && pready && pwrite;
    assign mapped = paddr == CTRL_ADDR || paddr == STAT_ADDR;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (paddr == CTRL_ADDR) begin
            rd_val[REG_W-1:0] = ctrl & CTRL_WMASK;
        end else if (paddr == STAT_ADDR) begin
            rd_val[ST_RUN] = run;
            rd_val[ST_PIN] = pin_sync;
            rd_val[ST_RSVD] = rsvd;
            rd_val[ST_PASS] = pass;
            rd_val[ST_UP] = up;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr <= !mapped;
        end
    end

    // reserved bits are dropped on write so they always read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RST;
        end else if (wr && paddr == CTRL_ADDR) begin
            ctrl <= pwdata[REG_W-1:0] & CTRL_WMASK;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_enable_off_low: assert property (
        !en |=> !run ##1 (!recovered_clock_out_first && !recovered_clock_gate))
        else $error("output active while disabled");

    a_source_port: assert property (
        next_run && lvl != SQ_OFF && typ == TYPE_SERDES |-> serdes_s[src[1:0]])
        else $error("clock runs from a port whose link is down");

    a_auto_squelch: assert property (
        lvl == SQ_AUTO && (unsup || eee_sq || !stable_s[sel]) |=> !run)
        else $error("level 00 failed to squelch");

    a_lpi_master: assert property (
        can && lvl == SQ_LPI && ok && unsup && !eee_sq |=> run)
        else $error("level 01 squelched master or 10BASE-T");

    a_lpi_idle: assert property (
        can && lvl == SQ_LPI && ok && eee_sq && lpi_s[sel] |=> run)
        else $error("level 01 squelched during LPI");

    a_link_only: assert property (
        can && lvl == SQ_LINK |=> run == $past(up))
        else $error("level 10 does not follow link");

    a_never_squelch: assert property (
        can && lvl == SQ_OFF |=> run)
        else $error("level 11 squelched");

    a_pin_override: assert property (
        pin_sync |=> !run ##1 (!recovered_clock_out_first && !recovered_clock_gate))
        else $error("squelch pin did not stop output");

    a_copper_type: assert property (
        next_run && lvl != SQ_OFF && typ != TYPE_SERDES |-> copper_s[src[1:0]])
        else $error("copper clock without copper link");

    a_reserved_low: assert property (
        rsvd |=> !run)
        else $error("reserved code produced a clock");

    // field checks read the raw fields, so a broken rsvd decode is still caught
    a_rsvd_src: assert property (
        src > SRC_MAX |=> !run)
        else $error("reserved source code produced a clock");

    a_rsvd_freq: assert property (
        freq > FREQ_31 |=> !run)
        else $error("reserved frequency code produced a clock");

    a_rsvd_type: assert property (
        typ > TYPE_CU_TX |=> !run)
        else $error("reserved clock type produced a clock");

    // the pins lag run by one edge; these look at the pins, not inside the divider
    a_out_needs_run: assert property (
        !run |=> !recovered_clock_out_first && !recovered_clock_gate)
        else $error("output moved without run");

    a_gate_on: assert property (
        run && freq == FREQ_125 |=> recovered_clock_gate)
        else $error("125 MHz gate missing at the pin");

    a_gate_freq: assert property (
        recovered_clock_gate |-> $past(run) && $past(freq) == FREQ_125)
        else $error("gate raised for a slow frequency");

    a_auto_down: assert property (
        lvl == SQ_AUTO && !ok |=> !run)
        else $error("level 00 ran on a down or unstable link");

    a_auto_pass: assert property (
        can && lvl == SQ_AUTO && ok && !unsup && !eee_sq |=> run)
        else $error("level 00 squelched a supported link");

    a_lpi_down: assert property (
        lvl == SQ_LPI && !ok |=> !run)
        else $error("level 01 ran on a down or unstable link");

    a_lpi_eee_hold: assert property (
        lvl == SQ_LPI && eee_sq && !lpi_s[sel] |=> !run)
        else $error("level 01 ran in EEE without LPI");

    a_link_down: assert property (
        lvl == SQ_LINK && !up |=> !run)
        else $error("level 10 ran with link down");

    a_serdes_down: assert property (
        lvl == SQ_LINK && typ == TYPE_SERDES && !serdes_s[sel] |=> !run)
        else $error("serdes clock without serdes link");

    a_copper_down: assert property (
        lvl == SQ_LINK && typ != TYPE_SERDES && !copper_s[sel] |=> !run)
        else $error("copper clock without copper link");

    a_off_down_runs: assert property (
        can && lvl == SQ_OFF && !up |=> run)
        else $error("level 11 squelched a down link");

    a_pin_blocks: assert property (
        pin_sync && lvl == SQ_OFF |=> !run)
        else $error("squelch pin ignored at level 11");

    a_ctrl_write: assert property (
        wr && paddr == CTRL_ADDR |=> ctrl == (REG_W'($past(pwdata)) & CTRL_WMASK))
        else $error("control write did not land");

    a_ctrl_hold: assert property (
        !(wr && paddr == CTRL_ADDR) |=> $stable(ctrl))
        else $error("control changed without a write");

    c_run_fast: cover property ($rose(recovered_clock_gate));
    c_run_slow: cover property ($rose(run) && freq == FREQ_25);
    c_pin_hit: cover property (run ##1 pin_sync);
    c_lpi_pass: cover property (can && lvl == SQ_LPI && eee_sq && lpi_s[sel]);
    c_auto_run: cover property (lvl == SQ_AUTO && next_run);

endmodule

// [core/rcs_pkg.sv]
// constants for the first recovered clock output selector
// assumes a 125 MHz APB clock, 32-bit data and one word per register
package rcs_pkg;

    localparam int ADDR_W = 12;
    localparam int REG_W = 16;

    // register indices; byte address is four times the index
    localparam logic [7:0] CTRL_INDEX = 8'h17;
    localparam logic [7:0] STAT_INDEX = 8'h20;
    localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_INDEX, 2'h0};
    localparam logic [11:0] STAT_ADDR = {2'h0, STAT_INDEX, 2'h0};

    // control field positions
    localparam int EN_BIT = 15;
    localparam int SRC_LSB = 11;
    localparam int FREQ_LSB = 8;
    localparam int LVL_LSB = 4;
    localparam int TYPE_LSB = 0;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'hFF37;

    // status field positions
    localparam int ST_RUN = 0;
    localparam int ST_PIN = 1;
    localparam int ST_RSVD = 2;
    localparam int ST_PASS = 3;
    localparam int ST_UP = 4;

    localparam logic [3:0] SRC_MAX = 4'h3;
    localparam logic [2:0] FREQ_25 = 3'h0;
    localparam logic [2:0] FREQ_125 = 3'h1;
    localparam logic [2:0] FREQ_31 = 3'h2;
    localparam logic [2:0] TYPE_SERDES = 3'h0;
    localparam logic [2:0] TYPE_CU_RX = 3'h1;
    localparam logic [2:0] TYPE_CU_TX = 3'h2;
    localparam logic [1:0] SQ_AUTO = 2'h0;
    localparam logic [1:0] SQ_LPI = 2'h1;
    localparam logic [1:0] SQ_LINK = 2'h2;
    localparam logic [1:0] SQ_OFF = 2'h3;

    // output rates in kHz and the pclk divide ratios derived from them
    localparam int PCLK_KHZ = 125000;
    localparam int F25_KHZ = 25000;
    localparam int F125_KHZ = 125000;
    localparam int F31_KHZ = 31250;
    localparam logic [2:0] DIV_25 = 3'(PCLK_KHZ / F25_KHZ);
    localparam logic [2:0] DIV_125 = 3'(PCLK_KHZ / F125_KHZ);
    localparam logic [2:0] DIV_31 = 3'(PCLK_KHZ / F31_KHZ);

    function automatic logic [2:0] div_of(input logic [2:0] f);
        case (f)
            FREQ_125: div_of = DIV_125;
            FREQ_31: div_of = DIV_31;
            default: div_of = DIV_25;
        endcase
    endfunction

endpackage

// [core/rcs_gen_if.sv]
// carrier between the selector core and its output divider
// assumes both ends run on the same pclk
`timescale 1ns/1ns
interface rcs_gen_if;
    logic run;
    logic [2:0] freq;
    logic wave;
    logic gate;
    modport ctl (output run, output freq, input wave, input gate);
    modport gen (input run, input freq, output wave, output gate);
endinterface

// [core/rcs_clk_gen.sv]
// output divider: makes the recovered clock wave from pclk
// assumes run and freq come from flops on the same pclk
`timescale 1ns/1ns
module rcs_clk_gen
    import rcs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    rcs_gen_if.gen g
);

    logic [2:0] cnt;
    logic [2:0] div;

    assign div = div_of(g.freq);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 3'h0;
        end else if (!g.run || cnt >= div - 3'h1) begin
            cnt <= 3'h0;
        end else begin
            cnt <= cnt + 3'h1;
        end
    end

    // 25 MHz is an odd divide: 2 of 5 cycles high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            g.wave <= 1'b0;
        end else begin
            g.wave <= g.run && g.freq != FREQ_125 && cnt < (div >> 1);
        end
    end

    // a flop cannot toggle at pclk rate, so 125 MHz leaves as a pad gate on pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            g.gate <= 1'b0;
        end else begin
            g.gate <= g.run && g.freq == FREQ_125;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_period_31m: assert property (
        $rose(g.wave) ##1 (g.run && g.freq == FREQ_31)[*4] |-> $rose(g.wave))
        else $error("31.25 MHz period is not 4 cycles");
    a_period_25m: assert property (
        $rose(g.wave) ##1 (g.run && g.freq == FREQ_25)[*5] |-> $rose(g.wave))
        else $error("25 MHz period is not 5 cycles");
    a_gate_fast: assert property (
        g.run && g.freq == FREQ_125 |=> g.gate && !g.wave)
        else $error("125 MHz gate not raised");

endmodule

// [bench/rcs_sync_sink.sv]
// board timing sink model: counts recovered clock rising edges and gated pclk cycles
// assumes both inputs are registered on pclk; clr is synchronous
`timescale 1ns/1ns
module rcs_sync_sink (
    input wire logic pclk,
    input wire logic clr,
    input wire logic clk_in,
    input wire logic gate_in,
    output int rises,
    output int gates
);
    logic last;
    always_ff @(posedge pclk) begin
        last <= clk_in;
        if (clr) begin
            rises <= 0;
            gates <= 0;
        end else begin
            rises <= rises + int'(clk_in & !last);
            gates <= gates + int'(gate_in);
        end
    end
endmodule

// [bench/tb.sv]
// self-checking bench for the first recovered clock output selector
// assumes rcs_top with four ports on a 125 MHz pclk
`timescale 1ns/1ns
module tb;
    import rcs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sq_pin, clr, err;
    logic rec_out, rec_gate;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] sd_up, cu_up, stab, s1000, s10, mst, eee, lpi;
    int rises, gates, miscompares, check_count;
    // {level, up, stable, 1000, 10, master, eee, lpi, runs}
    logic [9:0] sq_rows [14] = '{10'b00_0100000_0, 10'b01_0100000_0, 10'b10_0100000_0,
        10'b11_0100000_1, 10'b00_1110100_0, 10'b01_1110100_1, 10'b10_1110100_1,
        10'b00_1101000_0, 10'b01_1101000_1, 10'b00_1100010_0, 10'b01_1100010_0,
        10'b01_1100011_1, 10'b10_1000000_1, 10'b00_1100000_1};

    rcs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .clock_squelch_in(sq_pin), .serdes_link_up(sd_up),
        .copper_link_up(cu_up), .link_stable(stab), .speed_1000(s1000), .speed_10(s10),
        .phy_master(mst), .eee_mode(eee), .lpi_receive(lpi),
        .recovered_clock_out_first(rec_out), .recovered_clock_gate(rec_gate));
    rcs_sync_sink sink_u (.pclk(pclk), .clr(clr), .clk_in(rec_out), .gate_in(rec_gate),
        .rises(rises), .gates(gates));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // waits for pready with no cycle limit of its own; the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [15:0] cw(input logic [3:0] s, input logic [2:0] f,
        input logic [1:0] l, input logic [2:0] t);
        return {1'b1, s, f, 2'b00, l, 1'b0, t};
    endfunction

    task automatic set_link(input logic [3:0] sd, input logic [3:0] cu, input logic [6:0] c);
        @(posedge pclk);
        sd_up <= sd;
        cu_up <= cu;
        stab <= {4{c[5]}};
        s1000 <= {4{c[4]}};
        s10 <= {4{c[3]}};
        mst <= {4{c[2]}};
        eee <= {4{c[1]}};
        lpi <= {4{c[0]}};
    endtask

    // writes the control word, lets sync and divider settle, then counts for 40 cycles
    task automatic expect_out(input logic [15:0] c, input int er, input int eg);
        apb(1'b1, CTRL_ADDR, {16'h0000, c});
        repeat (8) @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (41) @(posedge pclk);
        check("clock rises", rises, er);
        check("gate cycles", gates, eg);
    endtask

    task automatic test_regs();
        apb(1'b0, CTRL_ADDR, 32'h0);
        check("ctrl reset", rd, 32'h0000_0000);
        check("idle out", {30'h0, rec_gate, rec_out}, 32'h0);
        apb(1'b1, CTRL_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, CTRL_ADDR, 32'h0);
        check("ctrl fields", rd, 32'h0000_FF37);
        apb(1'b0, 12'h100, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        $display("test regs done");
    endtask

    task automatic test_basic();
        set_link(4'hF, 4'h0, 7'b1100000);
        expect_out(16'h0020, 0, 0);
        expect_out(cw(4'h0, FREQ_25, SQ_LINK, TYPE_SERDES), 8, 0);
        expect_out(cw(4'h0, FREQ_125, SQ_LINK, TYPE_SERDES), 0, 40);
        expect_out(cw(4'h0, FREQ_31, SQ_LINK, TYPE_SERDES), 10, 0);
        for (int p = 0; p < 4; p++) begin
            set_link(4'(1 << p), 4'h0, 7'b0100000);
            expect_out(cw(4'(p), FREQ_25, SQ_LINK, TYPE_SERDES), 8, 0);
            expect_out(cw(4'((p + 1) % 4), FREQ_25, SQ_LINK, TYPE_SERDES), 0, 0);
        end
        $display("test basic done");
    endtask

    task automatic test_type();
        set_link(4'hF, 4'h0, 7'b0100000);
        expect_out(cw(4'h0, FREQ_25, SQ_LINK, TYPE_CU_RX), 0, 0);
        set_link(4'h0, 4'hF, 7'b0100000);
        expect_out(cw(4'h0, FREQ_25, SQ_LINK, TYPE_CU_RX), 8, 0);
        expect_out(cw(4'h0, FREQ_25, SQ_LINK, TYPE_CU_TX), 8, 0);
        expect_out(cw(4'h0, FREQ_25, SQ_LINK, TYPE_SERDES), 0, 0);
        expect_out(cw(4'h4, FREQ_25, SQ_OFF, TYPE_CU_RX), 0, 0);
        expect_out(cw(4'h0, 3'h3, SQ_OFF, TYPE_CU_RX), 0, 0);
        expect_out(cw(4'h0, FREQ_25, SQ_OFF, 3'h3), 0, 0);
        $display("test type done");
    endtask

    task automatic test_squelch();
        foreach (sq_rows[i]) begin
            set_link({4{sq_rows[i][7]}}, 4'h0, sq_rows[i][7:1]);
            expect_out(cw(4'h0, FREQ_25, sq_rows[i][9:8], TYPE_SERDES),
                sq_rows[i][0] ? 8 : 0, 0);
        end
        // status: run, pin, reserved, pass, link up from bit 0 upwards
        apb(1'b0, STAT_ADDR, 32'h0);
        check("status running", rd, 32'h0000_0019);
        sq_pin <= 1'b1;
        expect_out(cw(4'h0, FREQ_25, SQ_OFF, TYPE_SERDES), 0, 0);
        expect_out(cw(4'h0, FREQ_125, SQ_OFF, TYPE_SERDES), 0, 0);
        apb(1'b0, STAT_ADDR, 32'h0);
        check("status pin", rd, 32'h0000_001A);
        sq_pin <= 1'b0;
        $display("test squelch done");
    endtask

    task automatic give_verdict();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #160000;
        miscompares++;
        give_verdict();
    end

    initial begin
        {presetn, psel, penable, pwrite, sq_pin, clr} = 6'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        {sd_up, cu_up, stab, s1000, s10, mst, eee, lpi} = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_basic();
        test_type();
        test_squelch();
        give_verdict();
    end
endmodule
